// File: shared/pcsw_map.svh
// Behaviour
// - Output goes active at target, inactive later.
// - Targets are table entries first through last.
// - Enable-and-load copies the sequence into FIFO; a loaded, uncleared FIFO is resumed instead.
// - Works only for axis type 43, 44, 45.
// - Mode 0 disable, 1 enable+load, 2 clear.
// - Direction 0 decreasing, 1 increasing.
// - First target sets output to first level.
// - Each later target inverts output until last.
// - Disable stops switching, keeps FIFO contents.
`ifndef PCSW_MAP_SVH
`define PCSW_MAP_SVH
// Register byte offsets.
`define PCSW_OFS_CMD 8'h00
`define PCSW_OFS_AXTYPE 8'h04
`define PCSW_OFS_STATUS 8'h08
`define PCSW_TABLE_BASE_HI 2'h1
// Command register field positions.
`define PCSW_CMD_MODE_LSB 0
`define PCSW_CMD_DIR_BIT 4
`define PCSW_CMD_LEVEL_BIT 5
`define PCSW_CMD_START_LSB 8
`define PCSW_CMD_END_LSB 16
// Mode and direction codes.
`define PCSW_MODE_DISABLE 2'h0
`define PCSW_MODE_ENABLE 2'h1
`define PCSW_MODE_CLEAR 2'h2
`define PCSW_DIR_UP 1'h1
// Supported axis type codes.
`define PCSW_AXTYPE_A 8'h2b
`define PCSW_AXTYPE_B 8'h2c
`define PCSW_AXTYPE_C 8'h2d
// Reset values and bus answers.
`define PCSW_AXTYPE_RST 8'h00
`define PCSW_RESP_OKAY 2'h0
`define PCSW_RESP_SLVERR 2'h2
`endif

// File: shared/pcsw_pkg.sv
package pcsw_pkg;
   // Table and FIFO depth and index width.
   localparam int unsigned DEPTH = 16;
   typedef logic [3:0] pcsw_idx_t;
   typedef logic [31:0] pcsw_word_t;
   // Switch sequencer states, one-hot.
   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_ARMED = 4'h2,
      ST_RUN = 4'h4,
      ST_DONE = 4'h8
   } pcsw_state_e;
   // Register selector produced by the address decoder.
   typedef enum logic [2:0] {
      SEL_CMD = 3'h0,
      SEL_AXTYPE = 3'h1,
      SEL_STATUS = 3'h2,
      SEL_TABLE = 3'h3,
      SEL_NONE = 3'h4
   } pcsw_sel_e;
   // AXI4-Lite signals driven by the master.
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } pcsw_axi_req_s;
   // AXI4-Lite signals driven by the slave.
   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } pcsw_axi_rsp_s;
endpackage

// File: logic/pcsw_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcsw_map.svh"
module pcsw_top (
   // Clock and synchronous reset.
   input wire logic i_sys_clk,
   input wire logic i_srst,
   // Register bus.
   input wire pcsw_pkg::pcsw_axi_req_s i_axi,
   output logic [$bits(pcsw_pkg::pcsw_axi_rsp_s)-1:0] o_axi,
   // Axis feedback and switch output.
   input wire logic [31:0] i_meas_pos,
   output logic o_switch
);
   // Complete block state kept in one packed record.
   typedef struct packed {
      pcsw_pkg::pcsw_axi_rsp_s axi;
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [7:0] axis_type;
      pcsw_pkg::pcsw_state_e state;
      logic dir_up;
      logic first_level;
      logic out;
      logic loaded;
      pcsw_pkg::pcsw_idx_t rd_idx;
      logic [4:0] count;
      logic [pcsw_pkg::DEPTH-1:0][31:0] table_mem;
      logic [pcsw_pkg::DEPTH-1:0][31:0] fifo;
   } pcsw_regs_s;

   pcsw_regs_s state_r; // Registered state.
   pcsw_regs_s state_nxt; // Next state.

   // Maps a byte address to a register; used for both reads and writes.
   function automatic pcsw_pkg::pcsw_sel_e pcsw_decode(input logic [7:0] addr);
      pcsw_pkg::pcsw_sel_e sel;
      sel = pcsw_pkg::SEL_NONE;
      if (addr[1:0] != 2'h0) begin
         sel = pcsw_pkg::SEL_NONE;
      end else if (addr == `PCSW_OFS_CMD) begin
         sel = pcsw_pkg::SEL_CMD;
      end else if (addr == `PCSW_OFS_AXTYPE) begin
         sel = pcsw_pkg::SEL_AXTYPE;
      end else if (addr == `PCSW_OFS_STATUS) begin
         sel = pcsw_pkg::SEL_STATUS;
      end else if (addr[7:6] == `PCSW_TABLE_BASE_HI) begin
         sel = pcsw_pkg::SEL_TABLE;
      end
      return sel;
   endfunction

   // Merges written bytes into an old word under the byte strobes.
   function automatic logic [31:0] pcsw_merge(input logic [31:0] old, input logic [31:0] wr,
                                              input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            res[8*b +: 8] = wr[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Head entry, compare result and axis type check.
   pcsw_pkg::pcsw_word_t head; // Active target at the FIFO head.
   logic reached; // Measured position has reached or passed the head.
   logic type_ok; // Axis type supports the switch.
   pcsw_pkg::pcsw_sel_e wsel; // Decoded write target.
   pcsw_pkg::pcsw_sel_e rsel; // Decoded read target.
   logic [1:0] cmd_mode; // Mode field of a command write.
   pcsw_pkg::pcsw_idx_t cmd_start; // First table index of the sequence.
   pcsw_pkg::pcsw_idx_t cmd_end; // Last table index of the sequence.

   // Next-state logic for the bus slave and the switch sequencer.
   always_comb begin
      state_nxt = state_r;
      head = state_r.fifo[state_r.rd_idx];
      // Direction picks which side of the target counts as reached.
      if (state_r.dir_up == `PCSW_DIR_UP) begin
         reached = $signed(i_meas_pos) >= $signed(head);
      end else begin
         reached = $signed(i_meas_pos) <= $signed(head);
      end
      type_ok = (state_r.axis_type == `PCSW_AXTYPE_A) || (state_r.axis_type == `PCSW_AXTYPE_B) ||
                (state_r.axis_type == `PCSW_AXTYPE_C);
      wsel = pcsw_decode(state_r.aw_addr);
      rsel = pcsw_decode(i_axi.araddr);
      cmd_mode = state_r.w_data[`PCSW_CMD_MODE_LSB +: 2];
      cmd_start = state_r.w_data[`PCSW_CMD_START_LSB +: 4];
      cmd_end = state_r.w_data[`PCSW_CMD_END_LSB +: 4];

      // Sequencer: compare the head and pop it once it is reached.
      case (state_r.state)
         pcsw_pkg::ST_ARMED, pcsw_pkg::ST_RUN: begin
            if (!type_ok) begin
               // Axis type changed under us; stop but keep the queue.
               state_nxt.state = pcsw_pkg::ST_OFF;
            end else if (state_r.count == 5'h0) begin
               state_nxt.state = pcsw_pkg::ST_DONE;
            end else if (reached) begin
               if (state_r.state == pcsw_pkg::ST_ARMED) begin
                  state_nxt.out = state_r.first_level;
               end else begin
                  state_nxt.out = ~state_r.out;
               end
               state_nxt.state = pcsw_pkg::ST_RUN;
               state_nxt.rd_idx = pcsw_pkg::pcsw_idx_t'(state_r.rd_idx + 4'h1);
               state_nxt.count = state_r.count - 5'h1;
               // Popping the last entry ends the sequence.
               if (state_r.count == 5'h1) begin
                  state_nxt.state = pcsw_pkg::ST_DONE;
               end
            end
         end
         default: begin
            // Disabled or finished: the output holds its last level.
            state_nxt.state = state_r.state;
         end
      endcase

      // Write channel: address and data are accepted in either order.
      if (i_axi.awvalid && state_r.axi.awready) begin
         state_nxt.aw_got = 1'b1;
         state_nxt.aw_addr = i_axi.awaddr;
      end
      if (i_axi.wvalid && state_r.axi.wready) begin
         state_nxt.w_got = 1'b1;
         state_nxt.w_data = i_axi.wdata;
         state_nxt.w_strb = i_axi.wstrb;
      end
      if (state_r.axi.bvalid && i_axi.bready) begin
         state_nxt.axi.bvalid = 1'b0;
      end

      // Both halves held: perform the write and raise the response.
      if (state_r.aw_got && state_r.w_got && !state_r.axi.bvalid) begin
         state_nxt.aw_got = 1'b0;
         state_nxt.w_got = 1'b0;
         state_nxt.axi.bvalid = 1'b1;
         state_nxt.axi.bresp = `PCSW_RESP_OKAY;
         if (wsel == pcsw_pkg::SEL_CMD) begin
            // A command wins over a compare hit in the same cycle.
            if (cmd_mode == `PCSW_MODE_DISABLE) begin
               state_nxt.state = pcsw_pkg::ST_OFF;
               state_nxt.rd_idx = state_r.rd_idx;
               state_nxt.count = state_r.count;
               state_nxt.out = state_r.out;
            end else if (cmd_mode == `PCSW_MODE_CLEAR) begin
               state_nxt.state = pcsw_pkg::ST_OFF;
               state_nxt.rd_idx = 4'h0;
               state_nxt.count = 5'h0;
               state_nxt.loaded = 1'b0;
               // A compare hit in this cycle is dropped, so the output keeps its level.
               state_nxt.out = state_r.out;
            end else if (cmd_mode == `PCSW_MODE_ENABLE && type_ok) begin
               state_nxt.dir_up = state_r.w_data[`PCSW_CMD_DIR_BIT];
               state_nxt.first_level = state_r.w_data[`PCSW_CMD_LEVEL_BIT];
               // A queue that was loaded and never cleared is resumed, not reloaded,
               // so the controller must clear it before running the same list again.
               if (!state_r.loaded) begin
                  for (int i = 0; i < pcsw_pkg::DEPTH; i++) begin
                     state_nxt.fifo[i] =
                        state_r.table_mem[pcsw_pkg::pcsw_idx_t'(cmd_start + i[3:0])];
                  end
                  state_nxt.rd_idx = 4'h0;
                  state_nxt.count = (cmd_end >= cmd_start) ?
                     5'({1'b0, cmd_end} - {1'b0, cmd_start} + 5'h1) : 5'h0;
                  state_nxt.loaded = 1'b1;
                  state_nxt.state = pcsw_pkg::ST_ARMED;
               end else begin
                  // The command wins, so a hit in this same cycle is dropped.
                  state_nxt.out = state_r.out;
                  state_nxt.rd_idx = state_r.rd_idx;
                  state_nxt.count = state_r.count;
                  // Once an entry was popped the next hit must invert, so resume in run.
                  if (state_r.count == 5'h0) begin
                     state_nxt.state = pcsw_pkg::ST_DONE;
                  end else if (state_r.rd_idx != 4'h0) begin
                     state_nxt.state = pcsw_pkg::ST_RUN;
                  end else begin
                     state_nxt.state = pcsw_pkg::ST_ARMED;
                  end
               end
            end else begin
               // Unknown mode or unsupported axis: refused with an error.
               state_nxt.axi.bresp = `PCSW_RESP_SLVERR;
            end
         end else if (wsel == pcsw_pkg::SEL_AXTYPE) begin
            state_nxt.axis_type = 8'(pcsw_merge({24'h0, state_r.axis_type}, state_r.w_data,
                                                state_r.w_strb));
         end else if (wsel == pcsw_pkg::SEL_TABLE) begin
            state_nxt.table_mem[state_r.aw_addr[5:2]] =
               pcsw_merge(state_r.table_mem[state_r.aw_addr[5:2]], state_r.w_data,
                          state_r.w_strb);
         end else if (wsel == pcsw_pkg::SEL_NONE) begin
            state_nxt.axi.bresp = `PCSW_RESP_SLVERR;
         end
      end

      // Read channel: one read at a time, answered the cycle after it is taken.
      if (state_r.axi.rvalid && i_axi.rready) begin
         state_nxt.axi.rvalid = 1'b0;
      end
      if (i_axi.arvalid && state_r.axi.arready) begin
         state_nxt.axi.rvalid = 1'b1;
         state_nxt.axi.rresp = `PCSW_RESP_OKAY;
         state_nxt.axi.rdata = 32'h0;
         if (rsel == pcsw_pkg::SEL_AXTYPE) begin
            state_nxt.axi.rdata = {24'h0, state_r.axis_type};
         end else if (rsel == pcsw_pkg::SEL_STATUS) begin
            state_nxt.axi.rdata = {21'h0, state_r.count, state_r.loaded, state_r.out,
                                   state_r.state};
         end else if (rsel == pcsw_pkg::SEL_TABLE) begin
            state_nxt.axi.rdata = state_r.table_mem[i_axi.araddr[5:2]];
         end else if (rsel == pcsw_pkg::SEL_NONE) begin
            state_nxt.axi.rresp = `PCSW_RESP_SLVERR;
         end
      end

      // Ready flags come from flops so the bus outputs stay registered.
      state_nxt.axi.awready = !state_nxt.aw_got && !state_nxt.axi.bvalid;
      state_nxt.axi.wready = !state_nxt.w_got && !state_nxt.axi.bvalid;
      state_nxt.axi.arready = !state_nxt.axi.rvalid;
   end

   // State register with synchronous reset.
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         state_r <= '0;
         state_r.state <= pcsw_pkg::ST_OFF;
         state_r.axis_type <= `PCSW_AXTYPE_RST;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs taken straight from the state flops.
   assign o_axi = state_r.axi;
   assign o_switch = state_r.out;
endmodule
`default_nettype wire

// File: sim/pcsw_axis_model.sv
`timescale 1ns/1ps
`default_nettype none
// Axis feedback that slews toward a goal at a fixed rate.
// A slow slew means no target is ever jumped over.
module pcsw_axis_model #(
   parameter int STEP = 10
) (
   // Clock and goal.
   input wire logic i_sys_clk,
   input wire logic [31:0] i_goal,
   // Measured position.
   output logic [31:0] o_pos
);
   logic [31:0] pos_r = 32'h0; // Current position, starting at zero.
   assign o_pos = pos_r;
   // Step one increment per cycle toward the goal.
   always @(posedge i_sys_clk) begin
      if ($signed(pos_r) < $signed(i_goal)) begin
         pos_r <= pos_r + 32'(STEP);
      end else if ($signed(pos_r) > $signed(i_goal)) begin
         pos_r <= pos_r - 32'(STEP);
      end
   end
endmodule
`default_nettype wire

// File: sim/pcsw_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcsw_map.svh"
module pcsw_top_sva (
   // Clock, reset and bus.
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire pcsw_pkg::pcsw_axi_req_s i_axi,
   input wire logic [$bits(pcsw_pkg::pcsw_axi_rsp_s)-1:0] o_axi,
   // Axis side.
   input wire logic [31:0] i_meas_pos,
   input wire logic o_switch
);
   pcsw_pkg::pcsw_axi_rsp_s r; // Slave answer as a struct.
   logic [7:0] aw_r; // Address of the write in flight.
   logic [31:0] wd_r; // Data of the write in flight.
   logic [7:0] at_r; // Mirror of the axis type.
   logic off_r; // Switch known stopped; conservative, never set early.
   logic good; // Mirrored axis type is supported.
   assign r = o_axi;
   assign good = at_r inside {`PCSW_AXTYPE_A, `PCSW_AXTYPE_B, `PCSW_AXTYPE_C};
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_srst);
   // Follow each write once its answer appears.
   always_ff @(posedge i_sys_clk) begin
      if (i_axi.awvalid && r.awready) aw_r <= i_axi.awaddr;
      if (i_axi.wvalid && r.wready) wd_r <= i_axi.wdata;
      if (i_srst) begin
         at_r <= `PCSW_AXTYPE_RST;
         off_r <= 1'b1;
      end else if ($rose(r.bvalid) && r.bresp == `PCSW_RESP_OKAY) begin
         if (aw_r == `PCSW_OFS_AXTYPE) at_r <= wd_r[7:0];
         if (aw_r == `PCSW_OFS_CMD) off_r <= (wd_r[1:0] != `PCSW_MODE_ENABLE);
      end
   end
   a_bvalid_hold: assert property (r.bvalid && !i_axi.bready |=> r.bvalid)
      else $error("write answer dropped early");
   a_rvalid_hold: assert property (r.rvalid && !i_axi.rready |=> r.rvalid && $stable(r.rdata))
      else $error("read answer dropped early");
   a_read_answer: assert property (i_axi.arvalid && r.arready |=> r.rvalid && !r.arready)
      else $error("read answer late");
   a_write_answer: assert property (i_axi.awvalid && r.awready && i_axi.wvalid && r.wready
      |=> !r.bvalid ##1 r.bvalid) else $error("write answer timing");
   a_bad_mode: assert property ($rose(r.bvalid) && aw_r == `PCSW_OFS_CMD
      && wd_r[1:0] == 2'h3 |-> r.bresp == `PCSW_RESP_SLVERR)
      else $error("undefined mode accepted");
   a_type_gate: assert property ($rose(r.bvalid) && aw_r == `PCSW_OFS_CMD
      && wd_r[1:0] == `PCSW_MODE_ENABLE
      |-> r.bresp == (good ? `PCSW_RESP_OKAY : `PCSW_RESP_SLVERR)) else $error("axis type gate");
   a_stop_holds: assert property (off_r && !$rose(r.bvalid) |-> $stable(o_switch))
      else $error("output moved while stopped");
   a_reset_quiet: assert property (disable iff (1'b0) i_srst |=> !o_switch && !r.bvalid
      && !r.rvalid) else $error("outputs active in reset");
endmodule
bind pcsw_top pcsw_top_sva chk (.i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_axi(i_axi),
   .o_axi(o_axi), .i_meas_pos(i_meas_pos), .o_switch(o_switch));
`default_nettype wire

// File: sim/position_compare_output_fifo_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcsw_map.svh"
`define CHK(nm, got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module position_compare_output_fifo_tb;
   logic clk;
   logic srst = 1'b1; // Held for six cycles.
   pcsw_pkg::pcsw_axi_req_s req = '0; // Bus master side.
   logic [$bits(pcsw_pkg::pcsw_axi_rsp_s)-1:0] rsp_v;
   pcsw_pkg::pcsw_axi_rsp_s rsp;
   logic [31:0] goal = 32'h0; // Where the axis heads.
   logic [31:0] pos;
   logic sw;
   logic sw_q = 1'b0;
   logic [31:0] rdv;
   int flips = 0; // Edges seen on the switch output.
   int f0;
   int num_errors = 0;
   int n_tests = 0;
   int cycles = 0;
   assign rsp = rsp_v;
   pcsw_top dut (.i_sys_clk(clk), .i_srst(srst), .i_axi(req), .o_axi(rsp_v),
      .i_meas_pos(pos), .o_switch(sw));
   pcsw_axis_model axis (.i_sys_clk(clk), .i_goal(goal), .o_pos(pos));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Count output edges and cut a hang short.
   always @(posedge clk) begin
      sw_q <= sw;
      if (sw !== sw_q) flips++;
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         give_verdict();
      end
   end
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Write one word; each channel released once taken, answer checked.
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      logic done;
      done = 1'b0;
      @(posedge clk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= d;
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            done = 1'b1;
            req.bready <= 1'b0;
            `CHK("bresp", rsp.bresp, e)
         end
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic done;
      done = 1'b0;
      @(posedge clk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      while (!done) begin
         @(posedge clk);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            done = 1'b1;
            d = rsp.rdata;
            `CHK("rresp", rsp.rresp, `PCSW_RESP_OKAY)
            req.rready <= 1'b0;
         end
      end
   endtask
   // Command word: mode, direction, first level, first and last entry.
   function automatic logic [31:0] cmd(input logic [1:0] m, input logic dr, input logic lv,
      input logic [3:0] s, input logic [3:0] en);
      return {12'h0, en, 4'h0, s, 2'h0, lv, dr, 2'h0, m};
   endfunction
   // Write successive table entries starting at a value, stepping by a delta.
   task automatic fill(input int s, input int n, input int v, input int dv);
      for (int i = 0; i < n; i++) wr(8'h40 + 8'(4 * (s + i)), 32'(v + i * dv), 2'h0);
   endtask
   task automatic t_regs();
      rd(`PCSW_OFS_AXTYPE, rdv);
      `CHK("axtype", rdv[7:0], `PCSW_AXTYPE_RST)
      wr(8'h0c, 32'h1, `PCSW_RESP_SLVERR);
      wr(`PCSW_OFS_CMD, cmd(2'h1, 1'b1, 1'b1, 4'h1, 4'h0), `PCSW_RESP_SLVERR);
      wr(`PCSW_OFS_CMD, cmd(2'h3, 1'b0, 1'b0, 4'h0, 4'h0), `PCSW_RESP_SLVERR);
      for (int t = 43; t <= 45; t++) begin
         wr(`PCSW_OFS_AXTYPE, 32'(t), `PCSW_RESP_OKAY);
         wr(`PCSW_OFS_CMD, cmd(2'h1, 1'b1, 1'b1, 4'h1, 4'h0), `PCSW_RESP_OKAY);
         rd(`PCSW_OFS_STATUS, rdv);
         `CHK("empty run done", rdv[3:0], 4'h8)
         wr(`PCSW_OFS_CMD, cmd(2'h2, 1'b0, 1'b0, 4'h0, 4'h0), `PCSW_RESP_OKAY);
      end
      rd(`PCSW_OFS_AXTYPE, rdv);
      `CHK("axtype kept", rdv[7:0], `PCSW_AXTYPE_C)
      $display("test regs done");
   endtask
   task automatic t_up();
      fill(2, 4, 100, 100);
      rd(8'h48, rdv);
      `CHK("table entry", rdv, 32'h64)
      wr(`PCSW_OFS_CMD, cmd(2'h1, 1'b1, 1'b1, 4'h2, 4'h5), `PCSW_RESP_OKAY);
      f0 = flips;
      goal <= 32'd150;
      repeat (25) @(posedge clk);
      `CHK("first level", sw, 1'b1)
      goal <= 32'd450;
      repeat (40) @(posedge clk);
      `CHK("up edges", flips - f0, 4)
      `CHK("up last", sw, 1'b0)
      rd(`PCSW_OFS_STATUS, rdv);
      `CHK("up done", rdv[3:0], 4'h8)
      $display("test up done");
   endtask
   task automatic t_down();
      fill(6, 3, 300, -100);
      goal <= 32'd500;
      repeat (10) @(posedge clk);
      wr(`PCSW_OFS_CMD, cmd(2'h2, 1'b0, 1'b0, 4'h0, 4'h0), `PCSW_RESP_OKAY);
      wr(`PCSW_OFS_CMD, cmd(2'h1, 1'b0, 1'b0, 4'h6, 4'h8), `PCSW_RESP_OKAY);
      f0 = flips;
      goal <= 32'd250;
      repeat (30) @(posedge clk);
      `CHK("down first", sw, 1'b0)
      goal <= 32'd50;
      repeat (30) @(posedge clk);
      `CHK("down edges", flips - f0, 2)
      $display("test down done");
   endtask
   task automatic t_pause();
      fill(9, 2, 100, 100);
      wr(`PCSW_OFS_CMD, cmd(2'h2, 1'b0, 1'b0, 4'h0, 4'h0), `PCSW_RESP_OKAY);
      wr(`PCSW_OFS_CMD, cmd(2'h1, 1'b1, 1'b1, 4'h9, 4'ha), `PCSW_RESP_OKAY);
      goal <= 32'd150;
      repeat (20) @(posedge clk);
      wr(`PCSW_OFS_CMD, cmd(2'h0, 1'b0, 1'b0, 4'h0, 4'h0), `PCSW_RESP_OKAY);
      goal <= 32'd300;
      repeat (20) @(posedge clk);
      `CHK("held on stop", sw, 1'b1)
      rd(`PCSW_OFS_STATUS, rdv);
      `CHK("entries kept", {rdv[10:6], rdv[3:0]}, 9'h011)
      wr(`PCSW_OFS_CMD, cmd(2'h1, 1'b1, 1'b1, 4'h9, 4'ha), `PCSW_RESP_OKAY);
      repeat (5) @(posedge clk);
      `CHK("passed target", sw, 1'b0)
      $display("test pause done");
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_up();
      t_down();
      t_pause();
      give_verdict();
   end
endmodule
`default_nettype wire
